// ### hdl/crc_cold_redundancy.sv
// Cold-redundancy role register, wake line drive and converter run control
`timescale 1ns/100ps
module crc_cold_redundancy
  import crc_pkg::*;
(
  input  wire logic       clk,          // 10 MHz clock
  input  wire logic       srst,         // Synchronous reset, active high
  input  crc_cmd_t        cmdIn,        // Management command access
  output logic      [7:0] rdData,       // Read data for role command
  output logic            rdValid,      // Read data valid pulse
  input  wire logic       faultIn,      // Internal fault
  input  wire logic       underVolt,    // Common output below limit
  input  wire logic       wakeIn,       // Shared wake line level
  output logic            wakeOut,      // Shared wake line drive value
  output logic            wakeOe,       // Shared wake line drive enable
  input  crc_share_t      shareIn,      // Load-share comparisons
  output logic            converterRunN // Converter off request, active low run
);
  // Role register and read-back
  logic [7:0] role_r, role_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic       rdv_r, rdv_nxt;
  // Wake line edge history and drive
  logic       wakePrev_r, wakePrev_nxt;
  logic       wOut_r, wOut_nxt;
  logic       wOe_r, wOe_nxt;
  // Standby hysteresis and converter run
  logic       stbyOff_r, stbyOff_nxt;
  logic       runN_r, runN_nxt;
  // Decoded role and qualifiers
  crc_mode_t  mode;
  logic [1:0] pos;
  logic       fault;
  logic       wakeFall;
  logic       roleWr;
  logic       roleRd;
  logic       stbyRole;
  logic       loadHigh;
  logic       loadLow;

  // Only the role command is acted on; others pass by
  function automatic logic hitsRole(input logic strobe, input logic [7:0] code);
    hitsRole = strobe && (code == CRC_CMD_ROLE);
  endfunction

  crc_role_decode uDec (
    .roleByte (role_r),
    .mode     (mode),
    .position (pos)
  );

  assign fault    = faultIn | underVolt;
  assign wakeFall = wakePrev_r & ~wakeIn;
  assign roleWr   = hitsRole(cmdIn.wrEn, cmdIn.cmd);
  assign roleRd   = hitsRole(cmdIn.rdEn, cmdIn.cmd);
  assign stbyRole = (mode == CRC_M_STBY);
  assign loadHigh = shareIn.aboveEnable[pos];
  assign loadLow  = shareIn.belowDisable[pos];

  // Role register
  always_comb begin
    role_nxt = role_r;
    if (roleWr) begin
      role_nxt = cmdIn.wrData;
    end
    // Wake event wins over a simultaneous write
    if (wakeFall && stbyRole) begin
      role_nxt = CRC_ROLE_STD;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      role_r <= CRC_ROLE_RESET;
    end else begin
      role_r <= role_nxt;
    end
  end

  // Read-back of the stored role byte
  always_comb begin
    rd_nxt  = rd_r;
    rdv_nxt = 1'b0;
    if (roleRd) begin
      rd_nxt  = role_r;
      rdv_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_r  <= 8'h00;
      rdv_r <= 1'b0;
    end else begin
      rd_r  <= rd_nxt;
      rdv_r <= rdv_nxt;
    end
  end

  // Wake line edge history and drive
  always_comb begin
    wakePrev_nxt = wakeIn;
    wOe_nxt      = fault | (mode == CRC_M_ACTIVE);
    wOut_nxt     = ~fault;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wakePrev_r <= 1'b1;
      wOut_r     <= 1'b0;
      wOe_r      <= 1'b0;
    end else begin
      wakePrev_r <= wakePrev_nxt;
      wOut_r     <= wOut_nxt;
      wOe_r      <= wOe_nxt;
    end
  end

  // Standby hysteresis and converter run request
  always_comb begin
    stbyOff_nxt = stbyOff_r;
    if (loadHigh) begin
      stbyOff_nxt = 1'b0;
    end else if (loadLow) begin
      stbyOff_nxt = 1'b1;
    end
    // Sleep only while a healthy active unit holds wake high
    case (mode)
      CRC_M_STBY:   runN_nxt = wakeIn & stbyOff_nxt;
      CRC_M_ALWAYS: runN_nxt = wakeIn;
      default:      runN_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stbyOff_r <= 1'b0;
      runN_r    <= 1'b0;
    end else begin
      stbyOff_r <= stbyOff_nxt;
      runN_r    <= runN_nxt;
    end
  end

  assign converterRunN = runN_r;
  assign wakeOut       = wOut_r;
  assign wakeOe        = wOe_r;
  assign rdData        = rd_r;
  assign rdValid       = rdv_r;

  // Rule checks

  AST_FAULT_PULLS_LOW: assert property (@(posedge clk) disable iff (srst)
    fault |=> (wakeOe && !wakeOut)) else $error("fault did not pull wake low");
  AST_WAKE_LOW_RUNS: assert property (@(posedge clk) disable iff (srst)
    !wakeIn |=> !converterRunN) else $error("wake low but converter off");
  AST_WAKE_BOUND: assert property (@(posedge clk) disable iff (srst)
    $fell(wakeIn) |-> ##[0:2] !converterRunN) else $error("wake response too slow");
  AST_STD_ACTIVE_RUN: assert property (@(posedge clk) disable iff (srst)
    (mode == CRC_M_STD || mode == CRC_M_ACTIVE) |=> !converterRunN)
    else $error("redundant role converter off");
  AST_HEALTHY_STD_TRI: assert property (@(posedge clk) disable iff (srst)
    (!fault && mode != CRC_M_ACTIVE) |=> !wakeOe) else $error("healthy non-active drives wake");
  AST_ACTIVE_HIGH: assert property (@(posedge clk) disable iff (srst)
    (!fault && mode == CRC_M_ACTIVE) |=> (wakeOe && wakeOut)) else $error("active not high");
  AST_WAKE_RESETS_ROLE: assert property (@(posedge clk) disable iff (srst)
    (wakeFall && mode == CRC_M_STBY) |=> role_r == CRC_ROLE_STD) else $error("role not reset");
  AST_WRITE_TAKES: assert property (@(posedge clk) disable iff (srst)
    (cmdIn.wrEn && cmdIn.cmd == CRC_CMD_ROLE && !wakeFall) |=> role_r == $past(cmdIn.wrData))
    else $error("role write lost");
  AST_RESET_STD: assert property (@(posedge clk)
    srst |=> (role_r == CRC_ROLE_RESET && !converterRunN)) else $error("reset state wrong");
  AST_HYST_HOLD: assert property (@(posedge clk) disable iff (srst)
    (mode == CRC_M_STBY && !shareIn.aboveEnable[pos] && !shareIn.belowDisable[pos]
     && $stable(role_r)) |=> $stable(stbyOff_r)) else $error("hysteresis broken");

  // Wake line drive
  AST_UV_PULLS_LOW: assert property (@(posedge clk) disable iff (srst)
    underVolt |=> (wakeOe && !wakeOut)) else $error("undervoltage did not pull wake low");
  AST_ACTIVE_FAULT_LOW: assert property (@(posedge clk) disable iff (srst)
    (fault && mode == CRC_M_ACTIVE) |=> (wakeOe && !wakeOut))
    else $error("active unit fault not low");
  AST_RESET_DRIVE: assert property (@(posedge clk)
    srst |=> (!wakeOe && !wakeOut && !rdValid)) else $error("reset drive wrong");

  // Register access
  AST_READ_BACK: assert property (@(posedge clk) disable iff (srst)
    roleRd |=> (rdValid && rdData == $past(role_r))) else $error("role read-back wrong");
  AST_READ_PULSE: assert property (@(posedge clk) disable iff (srst)
    !roleRd |=> !rdValid) else $error("read valid without request");
  AST_READ_HOLDS: assert property (@(posedge clk) disable iff (srst)
    !roleRd |=> $stable(rdData)) else $error("read data changed unasked");
  AST_OTHER_CMD: assert property (@(posedge clk) disable iff (srst)
    (!roleWr && !(wakeFall && stbyRole)) |=> $stable(role_r))
    else $error("role changed unasked");

  // Role decode
  AST_DECODE_STBY: assert property (@(posedge clk) disable iff (srst)
    (role_r == CRC_ROLE_STBY1 || role_r == CRC_ROLE_STBY2 || role_r == CRC_ROLE_STBY3)
    |-> stbyRole) else $error("standby byte not decoded");
  AST_ALWAYS_SLEEPS: assert property (@(posedge clk) disable iff (srst)
    (role_r == CRC_ROLE_ALWAYS && wakeIn) |=> converterRunN)
    else $error("always standby ran");
  AST_ALWAYS_KEEPS: assert property (@(posedge clk) disable iff (srst)
    (role_r == CRC_ROLE_ALWAYS && !roleWr) |=> role_r == CRC_ROLE_ALWAYS)
    else $error("always standby role lost");

  // Converter run
  AST_LOAD_WAKES: assert property (@(posedge clk) disable iff (srst)
    (stbyRole && loadHigh) |=> !converterRunN)
    else $error("load above enable but off");
  AST_LOAD_SLEEPS: assert property (@(posedge clk) disable iff (srst)
    (stbyRole && wakeIn && !loadHigh && loadLow) |=> converterRunN)
    else $error("load below disable but on");
  AST_SLEEP_NEEDS_WAKE: assert property (@(posedge clk) disable iff (srst)
    converterRunN |-> $past(wakeIn)) else $error("asleep with wake low");

  COV_STBY_SLEEP: cover property (@(posedge clk) mode == CRC_M_STBY ##1 converterRunN);
  COV_WAKE_EVENT: cover property (@(posedge clk) wakeFall && mode == CRC_M_STBY);
  COV_ACTIVE_FAULT: cover property (@(posedge clk) mode == CRC_M_ACTIVE && fault);
  COV_ROLE_WRITE: cover property (@(posedge clk) roleWr);
  COV_ROLE_READ: cover property (@(posedge clk) roleRd ##1 rdValid);
endmodule

// ### hdl/crc_pkg.sv
// Package for the cold-redundancy role controller
package crc_pkg;
  localparam logic [7:0] CRC_CMD_ROLE       = 8'hd0;
  localparam logic [7:0] CRC_ROLE_RESET     = 8'h00;
  localparam logic [7:0] CRC_ROLE_STD       = 8'h00;
  localparam logic [7:0] CRC_ROLE_ACTIVE    = 8'h01;
  localparam logic [7:0] CRC_ROLE_STBY1     = 8'h02;
  localparam logic [7:0] CRC_ROLE_STBY2     = 8'h03;
  localparam logic [7:0] CRC_ROLE_STBY3     = 8'h04;
  localparam logic [7:0] CRC_ROLE_ALWAYS    = 8'h05;
  localparam int         CRC_CLK_MHZ        = 10;
  localparam int         CRC_WAKE_MAX_US    = 100;
  localparam int         CRC_WAKE_MAX_CYC   = CRC_WAKE_MAX_US * CRC_CLK_MHZ;

  typedef enum logic [2:0] {
    CRC_M_STD, CRC_M_ACTIVE, CRC_M_STBY, CRC_M_ALWAYS
  } crc_mode_t;

  // Comparator results per standby position, already synchronous
  typedef struct packed {
    logic [2:0] aboveEnable;
    logic [2:0] belowDisable;
  } crc_share_t;

  // Register access port from the management-bus engine
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] cmd;
    logic [7:0] wrData;
  } crc_cmd_t;
endpackage

// ### hdl/crc_role_decode.sv
// Role byte decoder: mode and standby position
`timescale 1ns/100ps
module crc_role_decode
  import crc_pkg::*;
(
  input  wire logic [7:0] roleByte,  // Current role byte
  output crc_mode_t       mode,      // Decoded role class
  output logic      [1:0] position   // Standby position index 0..2
);
  always_comb begin
    position = 2'd0;
    case (roleByte)
      CRC_ROLE_ACTIVE: mode = CRC_M_ACTIVE;
      CRC_ROLE_STBY1: begin
        mode     = CRC_M_STBY;
        position = 2'd0;
      end
      CRC_ROLE_STBY2: begin
        mode     = CRC_M_STBY;
        position = 2'd1;
      end
      CRC_ROLE_STBY3: begin
        mode     = CRC_M_STBY;
        position = 2'd2;
      end
      CRC_ROLE_ALWAYS: mode = CRC_M_ALWAYS;
      default: mode = CRC_M_STD;
    endcase
  end
endmodule

// ### verification/crc_peer_model.sv
// Peer supply on the shared wake line
`timescale 1ns/100ps
module crc_peer_model (
  input  wire logic clk,      // Clock
  input  wire logic beActive, // Peer holds always-on role
  input  wire logic hasFault, // Peer fault
  output logic      wakeOut,  // Drive value
  output logic      wakeOe    // Drive enable
);
  always_ff @(posedge clk) begin
    wakeOe  <= beActive | hasFault;
    wakeOut <= beActive & ~hasFault;
  end
endmodule

// ### verification/crc_cold_redundancy_tb.sv
// Bench for the cold-redundancy controller
`timescale 1ns/100ps
module crc_cold_redundancy_tb import crc_pkg::*; ;
  logic       clk, srst, faultIn, underVolt, wakeOut, wakeOe, runN, rdValid;
  logic       peerActive, peerFault, peerOut, peerOe, wakeLine;
  logic [7:0] rdData;
  crc_cmd_t   cmdIn;
  crc_share_t shareIn;
  int         mismatches, nCompared;
  // No pull-up: an undriven line reads low
  assign wakeLine = ((wakeOe & ~wakeOut) | (peerOe & ~peerOut)) ? 1'b0
                  : ((wakeOe & wakeOut) | (peerOe & peerOut));
  crc_cold_redundancy uut (.clk(clk), .srst(srst), .cmdIn(cmdIn), .rdData(rdData),
    .rdValid(rdValid), .faultIn(faultIn), .underVolt(underVolt), .wakeIn(wakeLine),
    .wakeOut(wakeOut), .wakeOe(wakeOe), .shareIn(shareIn), .converterRunN(runN));
  crc_peer_model peer (.clk(clk), .beActive(peerActive), .hasFault(peerFault),
    .wakeOut(peerOut), .wakeOe(peerOe));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task complete_run;
    if (mismatches == 0 && nCompared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    nCompared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task settle;
    repeat (3) @(negedge clk);
  endtask
  task wr(input logic [7:0] c, input logic [7:0] d);
    @(negedge clk);
    cmdIn = '{wrEn: 1'b1, rdEn: 1'b0, cmd: c, wrData: d};
    @(negedge clk);
    cmdIn.wrEn = 1'b0;
  endtask
  task rd(input logic [7:0] exp);
    @(negedge clk);
    cmdIn.rdEn = 1'b1;
    cmdIn.cmd  = CRC_CMD_ROLE;
    @(negedge clk);
    cmdIn.rdEn = 1'b0;
    chk("rdValid", 8'h01, {7'h00, rdValid});
    chk("role", exp, rdData);
  endtask
  task t_reset;
    rd(CRC_ROLE_RESET);
    chk("runN", 8'h00, {7'h00, runN});
    chk("wakeOe", 8'h00, {7'h00, wakeOe});
  endtask
  task t_active;
    wr(CRC_CMD_ROLE, CRC_ROLE_ACTIVE);
    wr(8'hd1, CRC_ROLE_STBY2);
    settle;
    rd(CRC_ROLE_ACTIVE);
    chk("wake hi", 8'h03, {6'h00, wakeOe, wakeOut});
    chk("runN", 8'h00, {7'h00, runN});
    faultIn = 1'b1;
    settle;
    chk("wake flt", 8'h02, {6'h00, wakeOe, wakeOut});
    faultIn   = 1'b0;
    underVolt = 1'b1;
    settle;
    chk("wake uv", 8'h02, {6'h00, wakeOe, wakeOut});
    underVolt = 1'b0;
    wr(CRC_CMD_ROLE, CRC_ROLE_STD);
    settle;
    chk("wake std", 8'h00, {7'h00, wakeOe});
  endtask
  task t_standby;
    peerActive = 1'b1;
    for (int p = 0; p < 3; p++) begin
      shareIn = {3'h0, 3'h7};
      wr(CRC_CMD_ROLE, CRC_ROLE_STBY1 + 8'(p));
      settle;
      chk("runN sleep", 8'h01, {7'h00, runN});
      shareIn = {~(3'h1 << p), 3'h7};
      settle;
      chk("runN other", 8'h01, {7'h00, runN});
      shareIn = {(3'h1 << p), 3'h0};
      settle;
      chk("runN on", 8'h00, {7'h00, runN});
      shareIn = 6'h00;
      settle;
      chk("runN hold", 8'h00, {7'h00, runN});
      shareIn = {3'h0, (3'h1 << p)};
      settle;
      chk("runN off", 8'h01, {7'h00, runN});
    end
  endtask
  task t_wake;
    peerFault = 1'b1;
    repeat (2) @(negedge clk);
    chk("runN wake", 8'h00, {7'h00, runN});
    rd(CRC_ROLE_STD);
    peerFault = 1'b0;
    settle;
  endtask
  task t_always;
    shareIn = {3'h7, 3'h0};
    wr(CRC_CMD_ROLE, CRC_ROLE_ALWAYS);
    settle;
    chk("runN always", 8'h01, {7'h00, runN});
    peerActive = 1'b0;
    settle;
    chk("runN noact", 8'h00, {7'h00, runN});
    rd(CRC_ROLE_ALWAYS);
  endtask
  initial begin
    {srst, faultIn, underVolt, peerActive, peerFault} = 5'h10;
    cmdIn      = '0;
    shareIn    = '0;
    mismatches = 0;
    nCompared  = 0;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    t_reset;
    t_active;
    t_standby;
    t_wake;
    t_always;
    complete_run;
  end
  initial begin
    #2000000;
    mismatches++;
    complete_run;
  end
endmodule
